/* hw/sdrci_pkg.sv */
// Package for the SDRAM command interface: command codes, widths, timing counts.
// Assumes a 25 MHz core clock; all counts are in core clock cycles.
package sdrci_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int DATA_W = 16;
  localparam int MASK_W = 2;
  localparam int NBANK = 4;
  localparam int MEM_AW = 8;
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int MODE_W = 12;
  localparam logic [11:0] MODE_RESET = 12'h000;
  // ----------------------------------------
  // Command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM = 4'h6;
  localparam logic [3:0] CMD_PRECH = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODELOAD = 4'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PRECHARGE_RECOVERY_NS = 20;
  localparam int ACTIVATE_NS = 20;
  localparam int MODE_LOAD_DELAY_CK = 2;
  localparam int REFRESH_NS = 80;
  localparam int PRECHARGE_RECOVERY_CK = (PRECHARGE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACTIVATE_CK = (ACTIVATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CK = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_MASK_DELAY = 2;
  localparam logic [3:0] BURST_LEN = 4'h4;
  // Bank states
  typedef enum logic [2:0] {BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING, BK_PRECHARGING} sdrci_bank_t;
endpackage

/* hw/sdrci_mem.sv */
// Small byte-masked array standing in for the cell array.
// Assumes one access per cycle; read data are registered.
`timescale 1ns/1ps
module sdrci_mem
  import sdrci_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Write side
  input wire logic wrEn,
  input wire logic [MASK_W-1:0] wrByteEn,
  input wire logic [MEM_AW-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read side
  input wire logic [MEM_AW-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  // Each lane owns its own cell array so no two processes write one array
  for (genvar b = 0; b < MASK_W; b++) begin : g_lane
    logic [7:0] cells [0:(1<<MEM_AW)-1];
    always_ff @(posedge core_clk) begin
      if (wrEn && wrByteEn[b]) begin
        cells[wrAddr] <= wrData[b*8 +: 8];
      end
      rdData[b*8 +: 8] <= cells[rdAddr]; // Registered read port
    end
  end
endmodule

/* hw/sdrci_core.sv */
// Command decode, per-bank state, burst engine and mask timing of a four-bank SDRAM.
// Assumes the controller drives all inputs synchronous to core_clk and obeys timing.
`timescale 1ns/1ps
// How it works
// RULE_01 - All inputs are sampled on the rising core clock edge.
// RULE_02 - Command decoded from chip select, row, column strobe and write enable.
// RULE_03 - Chip select high ignores new commands; ongoing work continues.
// RULE_04 - No-operation starts nothing; ongoing operations continue.
// RULE_05 - Activate opens addressed row in selected bank until precharged.
// RULE_06 - Controller precharges a bank before opening another row there.
// RULE_07 - Read or write takes bank and column; bit 10 selects auto precharge.
// RULE_08 - Auto precharge closes the row at burst end, else row stays open.
// RULE_09 - Read mask high floats those data pins two clocks later.
// RULE_10 - Write mask applies in the data cycle; high bytes are left unchanged.
// RULE_11 - Precharge with bit 10 low closes one bank, high closes all.
// RULE_12 - Controller waits recovery time and activates before accessing again.
// RULE_13 - Burst terminate truncates the latest read or write burst.
// RULE_14 - Terminate code with clock enable low enters deepest sleep.
// RULE_15 - Refresh code: auto refresh with clock enable high, else self refresh.
// RULE_16 - Refresh uses internal row counter; other inputs are ignored.
// RULE_17 - Controller loads mode only with all banks idle, then waits.
// RULE_18 - Mode load writes address bits 11 to 0 into the mode register.
// RULE_19 - Controller keeps clock enable high except for sleep entries.
// RULE_20 - After mode load only no-operation or deselect until delay passes.
// RULE_21 - Per-bank state decides whether each decoded command is legal.
module sdrci_core
  import sdrci_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Command pins
  input wire logic clkEn,
  input wire logic chipSel_n,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEn_n,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [ADDR_W-1:0] addr,
  // Data pins
  input wire logic [MASK_W-1:0] byteMask,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic [MASK_W-1:0] dataOe,
  // Status
  output logic [MODE_W-1:0] modeReg,
  output logic selfRefresh,
  output logic deepest_sleep,
  output logic illegalCmd,
  output logic [ADDR_W-1:0] refreshRow
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [3:0] cmd;
  logic [1:0] bank;
  logic asleep;
  assign cmd = {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n}; // RULE_01 RULE_02
  assign bank = {bank_select_hi, bank_select_lo};
  assign asleep = selfRefresh | deepest_sleep;
  logic isAct, isRd, isWr, isTerm, isPre, isRef, isMode, isSleepDp, isSleepSr;
  // Chip select high masks every code; sleep blocks all but wake
  assign isAct = !asleep && clkEn && cmd == CMD_ACTIVE; // RULE_03 RULE_04
  assign isRd = !asleep && clkEn && cmd == CMD_READ;
  assign isWr = !asleep && clkEn && cmd == CMD_WRITE;
  assign isTerm = !asleep && clkEn && cmd == CMD_TERM; // RULE_14
  assign isSleepDp = !asleep && !clkEn && cmd == CMD_TERM; // RULE_14
  assign isPre = !asleep && clkEn && cmd == CMD_PRECH;
  assign isRef = !asleep && clkEn && cmd == CMD_REFRESH; // RULE_15
  assign isSleepSr = !asleep && !clkEn && cmd == CMD_REFRESH; // RULE_15
  assign isMode = !asleep && clkEn && cmd == CMD_MODELOAD;

  // ----------------------------------------
  // Bank state and burst engine
  // ----------------------------------------
  sdrci_bank_t bankSt [NBANK], next_bankSt [NBANK];
  logic [ADDR_W-1:0] openRow [NBANK], next_openRow [NBANK];
  logic [1:0] bankTmr [NBANK], next_bankTmr [NBANK];
  logic [NBANK-1:0] apPend, next_apPend;
  logic [3:0] burstLeft, next_burstLeft;
  logic burstWr, next_burstWr;
  logic [1:0] burstBank, next_burstBank;
  logic [COL_W-1:0] burstCol, next_burstCol;
  logic [2:0] devTmr, next_devTmr;
  logic [MODE_W-1:0] next_modeReg;
  logic [ADDR_W-1:0] next_refreshRow;
  logic next_selfRefresh, next_sleep, next_illegal;
  logic allIdle;
  always_comb begin
    allIdle = 1'b1;
    for (int i = 0; i < NBANK; i++) begin
      allIdle = allIdle & (bankSt[i] == BK_IDLE);
    end
  end

  // Next state of banks, burst and device-wide timers
  always_comb begin
    next_burstLeft = burstLeft;
    next_burstWr = burstWr;
    next_burstBank = burstBank;
    next_burstCol = burstCol;
    next_apPend = apPend;
    next_devTmr = (devTmr != 3'h0) ? devTmr - 3'h1 : 3'h0;
    next_modeReg = modeReg;
    next_refreshRow = refreshRow;
    next_selfRefresh = selfRefresh && !clkEn;
    next_sleep = deepest_sleep && !clkEn;
    next_illegal = 1'b0;
    for (int i = 0; i < NBANK; i++) begin
      next_bankSt[i] = bankSt[i];
      next_openRow[i] = openRow[i];
      next_bankTmr[i] = (bankTmr[i] != 2'h0) ? bankTmr[i] - 2'h1 : 2'h0;
      unique case (bankSt[i])
        BK_ACTIVATING: if (bankTmr[i] <= 2'h1) next_bankSt[i] = BK_ACTIVE;
        BK_PRECHARGING: if (bankTmr[i] <= 2'h1) next_bankSt[i] = BK_IDLE;
        default: ;
      endcase
    end
    // Burst advance; natural end closes the row when auto precharge was set
    if (burstLeft != 4'h0) begin
      next_burstLeft = burstLeft - 4'h1;
      next_burstCol = burstCol + 9'h001;
      if (burstLeft == 4'h1) begin
        next_bankSt[burstBank] = apPend[burstBank] ? BK_PRECHARGING : BK_ACTIVE; // RULE_08
        next_bankTmr[burstBank] = 2'(PRECHARGE_RECOVERY_CK);
        next_apPend[burstBank] = 1'b0;
      end
    end
    // New command; a busy device refuses executable commands
    if (devTmr != 3'h0 && (isAct || isRd || isWr || isPre || isRef || isMode)) begin
      next_illegal = 1'b1;
    end else if (isAct) begin
      if (bankSt[bank] == BK_IDLE) begin // RULE_21
        next_bankSt[bank] = BK_ACTIVATING; // RULE_05
        next_openRow[bank] = addr;
        next_bankTmr[bank] = 2'(ACTIVATE_CK);
      end else begin
        next_illegal = 1'b1;
      end
    end else if (isRd || isWr) begin
      if (bankSt[bank] inside {BK_ACTIVE, BK_READING, BK_WRITING} && !apPend[bank]) begin // RULE_21
        if (burstLeft != 4'h0 && burstBank != bank) begin
          next_bankSt[burstBank] = apPend[burstBank] ? BK_PRECHARGING : BK_ACTIVE;
          next_bankTmr[burstBank] = 2'(PRECHARGE_RECOVERY_CK);
          next_apPend[burstBank] = 1'b0;
        end
        next_bankSt[bank] = isRd ? BK_READING : BK_WRITING;
        next_apPend[bank] = addr[AUTO_PRECHARGE_BIT]; // RULE_07
        next_burstLeft = BURST_LEN;
        next_burstWr = isWr;
        next_burstBank = bank;
        next_burstCol = addr[COL_W-1:0]; // RULE_07
      end else begin
        next_illegal = 1'b1;
      end
    end else if (isTerm) begin
      if (burstLeft != 4'h0) begin
        next_burstLeft = 4'h0; // RULE_13
        next_bankSt[burstBank] = apPend[burstBank] ? BK_PRECHARGING : BK_ACTIVE;
        next_bankTmr[burstBank] = 2'(PRECHARGE_RECOVERY_CK);
        next_apPend[burstBank] = 1'b0;
      end
    end else if (isPre) begin
      for (int i = 0; i < NBANK; i++) begin
        if ((addr[AUTO_PRECHARGE_BIT] || bank == 2'(i)) && bankSt[i] != BK_IDLE) begin // RULE_11
          next_bankSt[i] = BK_PRECHARGING;
          next_bankTmr[i] = 2'(PRECHARGE_RECOVERY_CK);
          next_apPend[i] = 1'b0;
          if (burstBank == 2'(i)) next_burstLeft = 4'h0;
        end
      end
    end else if (isRef || isSleepSr || isMode || isSleepDp) begin
      if (!allIdle) begin
        next_illegal = 1'b1;
      end else if (isRef) begin
        next_refreshRow = refreshRow + 13'h0001; // RULE_16
        next_devTmr = 3'(REFRESH_CK);
      end else if (isSleepSr) begin
        next_selfRefresh = 1'b1;
      end else if (isMode) begin
        next_modeReg = addr[MODE_W-1:0]; // RULE_18
        next_devTmr = 3'(MODE_LOAD_DELAY_CK);
      end else begin
        next_sleep = 1'b1;
      end
    end
  end

  // Register bank, burst and device state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NBANK; i++) begin
        bankSt[i] <= BK_IDLE;
        openRow[i] <= '0;
        bankTmr[i] <= 2'h0;
      end
      apPend <= '0;
      burstLeft <= 4'h0;
      burstWr <= 1'b0;
      burstBank <= 2'h0;
      burstCol <= '0;
      devTmr <= 3'h0;
      modeReg <= MODE_RESET;
      refreshRow <= '0;
      selfRefresh <= 1'b0;
      deepest_sleep <= 1'b0;
      illegalCmd <= 1'b0;
    end else begin
      bankSt <= next_bankSt;
      openRow <= next_openRow;
      bankTmr <= next_bankTmr;
      apPend <= next_apPend;
      burstLeft <= next_burstLeft;
      burstWr <= next_burstWr;
      burstBank <= next_burstBank;
      burstCol <= next_burstCol;
      devTmr <= next_devTmr;
      modeReg <= next_modeReg;
      refreshRow <= next_refreshRow;
      selfRefresh <= next_selfRefresh;
      deepest_sleep <= next_sleep;
      illegalCmd <= next_illegal;
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  logic wrBeat, rdBeat;
  logic [MEM_AW-1:0] beatAddr;
  logic [DATA_W-1:0] memRd;
  assign wrBeat = (burstLeft != 4'h0) && burstWr;
  assign rdBeat = (burstLeft != 4'h0) && !burstWr;
  // Array index folds bank and low column bits; the small array aliases rows
  assign beatAddr = {burstBank, burstCol[MEM_AW-3:0]};
  // Write beats start the cycle after the write command is taken
  sdrci_mem u_mem (
    .core_clk(core_clk),
    .wrEn(wrBeat),
    .wrByteEn(~byteMask), // RULE_10
    .wrAddr(beatAddr),
    .wrData(dataIn),
    .rdAddr(beatAddr),
    .rdData(memRd)
  );
  // Read valid and mask pipelines, both two clocks deep
  logic [MASK_W-1:0] maskDly1, maskDly2, next_maskDly1, next_maskDly2;
  logic rdDly1, rdDly2, next_rdDly1, next_rdDly2;
  logic [DATA_W-1:0] next_dataOut;
  always_comb begin
    next_maskDly1 = byteMask;
    next_maskDly2 = maskDly1;
    next_rdDly1 = rdBeat;
    next_rdDly2 = rdDly1;
    next_dataOut = memRd;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      maskDly1 <= '0;
      maskDly2 <= '0;
      rdDly1 <= 1'b0;
      rdDly2 <= 1'b0;
      dataOut <= '0;
    end else begin
      maskDly1 <= next_maskDly1;
      maskDly2 <= next_maskDly2; // RULE_09
      rdDly1 <= next_rdDly1;
      rdDly2 <= next_rdDly2;
      dataOut <= next_dataOut;
    end
  end
  assign dataOe = {MASK_W{rdDly2}} & ~maskDly2; // RULE_09

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_maskHigh;
    (rdBeat && byteMask[0]) ##1 1'b1;
  endsequence
  a_mask_float: assert property (@(posedge core_clk) disable iff (srst)
    s_maskHigh |=> !dataOe[0]) // RULE_09
    else $error("masked read byte driven");
  a_mask_drive: assert property (@(posedge core_clk) disable iff (srst)
    (rdBeat && !byteMask[0]) ##2 1'b1 |-> dataOe[0]) // RULE_09
    else $error("unmasked read byte not driven");
  a_deselect_ignored: assert property (@(posedge core_clk) disable iff (srst)
    chipSel_n |=> !illegalCmd && $stable(modeReg)) // RULE_03
    else $error("deselect changed state");
  a_nop_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (cmd == CMD_NOP && burstLeft == 4'h0) |=> $stable(burstLeft) && $stable(modeReg)) // RULE_04
    else $error("nop started an action");
  a_act_opens: assert property (@(posedge core_clk) disable iff (srst)
    (isAct && devTmr == 3'h0 && bankSt[bank] == BK_IDLE) |=> bankSt[$past(bank)] == BK_ACTIVATING
      && openRow[$past(bank)] == $past(addr)) // RULE_05
    else $error("activate did not open row");
  a_burst_start: assert property (@(posedge core_clk) disable iff (srst)
    (isRd && devTmr == 3'h0 && bankSt[bank] == BK_ACTIVE && !apPend[bank]) |=>
      burstLeft == BURST_LEN && burstCol == $past(addr[COL_W-1:0])) // RULE_07
    else $error("read burst not started");
  a_term_stops: assert property (@(posedge core_clk) disable iff (srst)
    isTerm |=> burstLeft == 4'h0) // RULE_13
    else $error("terminate did not stop burst");
  a_mode_load: assert property (@(posedge core_clk) disable iff (srst)
    (isMode && allIdle && devTmr == 3'h0) |=> modeReg == $past(addr[MODE_W-1:0])
      && devTmr == 3'(MODE_LOAD_DELAY_CK)) // RULE_18
    else $error("mode register not loaded");
  a_pre_all: assert property (@(posedge core_clk) disable iff (srst)
    (isPre && devTmr == 3'h0 && addr[AUTO_PRECHARGE_BIT] && bankSt[2] == BK_ACTIVE) |=>
      bankSt[2] == BK_PRECHARGING) // RULE_11
    else $error("precharge all missed a bank");
  a_self_ref: assert property (@(posedge core_clk) disable iff (srst)
    (isSleepSr && allIdle && devTmr == 3'h0) |=> selfRefresh) // RULE_15
    else $error("self refresh not entered");
  a_dpd_entry: assert property (@(posedge core_clk) disable iff (srst)
    (isSleepDp && allIdle && devTmr == 3'h0) |=> deepest_sleep) // RULE_14
    else $error("deep sleep not entered");
  a_auto_pre: assert property (@(posedge core_clk) disable iff (srst)
    (burstLeft == 4'h1 && apPend[burstBank]) |=> bankSt[$past(burstBank)] == BK_PRECHARGING) // RULE_08
    else $error("auto precharge missed");
  a_refresh_row: assert property (@(posedge core_clk) disable iff (srst)
    (isRef && allIdle && devTmr == 3'h0) |=> refreshRow == $past(refreshRow) + 13'h0001) // RULE_16
    else $error("refresh counter not stepped");
endmodule

/* tb/sdrci_ctrl_model.sv */
// Controller-side partner: drives command, address, mask and write data pins of the core.
// Assumes the bench calls one task at a time; every cycle carries exactly one command.
`timescale 1ns/1ps
module sdrci_ctrl_model
  import sdrci_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Command pins
  output logic clkEn,
  output logic chipSel_n,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeEn_n,
  output logic bank_select_lo,
  output logic bank_select_hi,
  output logic [ADDR_W-1:0] addr,
  // Data pins
  output logic [MASK_W-1:0] byteMask,
  output logic [DATA_W-1:0] dataIn
);
  // Deselected and idle from time zero
  initial begin
    clkEn = 1'b1;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = 4'hf;
    {bank_select_hi, bank_select_lo} = 2'h0;
    addr = '0;
    byteMask = '0;
    dataIn = 16'h5a5a;
  end

  // ----------------------------------------
  // Cycle primitive and command helpers
  // ----------------------------------------
  // Pins move at the falling edge so they are steady at the sampling edge
  task automatic cyc(input logic [3:0] code, input logic [1:0] bank, input logic [ADDR_W-1:0] a,
                     input logic cke, input logic [MASK_W-1:0] m, input logic [DATA_W-1:0] d, input logic dv);
    @(negedge core_clk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = code;
    clkEn = cke;
    {bank_select_hi, bank_select_lo} = bank;
    addr = a;
    byteMask = m;
    // Outside write beats the data lines flip, so a stale word never passes for data
    dataIn = dv ? d : ~dataIn;
    @(posedge core_clk);
  endtask
  // Idle cycles fill every wait
  task automatic nop(input int n);
    repeat (n) cyc(CMD_NOP, 2'h0, ~addr, 1'b1, 2'h0, 16'h0, 1'b0);
  endtask
  // Open a row, then wait out the activate time; callers close a bank before reopening it
  task automatic act(input logic [1:0] bank, input logic [ADDR_W-1:0] row);
    cyc(CMD_ACTIVE, bank, row, 1'b1, 2'h0, 16'h0, 1'b0);
    nop(ACTIVATE_CK);
  endtask
  // Close one bank or all, then honour the recovery time
  task automatic pre(input logic [1:0] bank, input logic all);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[AUTO_PRECHARGE_BIT] = all;
    cyc(CMD_PRECH, bank, a, 1'b1, 2'h0, 16'h0, 1'b0);
    nop(PRECHARGE_RECOVERY_CK);
  endtask
  // Mode load only from all-idle, then idle cycles for the load delay
  task automatic modeLoad(input logic [ADDR_W-1:0] op);
    cyc(CMD_MODELOAD, 2'h3, op, 1'b1, 2'h0, 16'h0, 1'b0);
    nop(MODE_LOAD_DELAY_CK);
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the SDRAM command core, driven through the controller partner.
// Assumes sdrci_pkg, sdrci_core and sdrci_ctrl_model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
  import sdrci_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clkEn, chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, bank_select_lo, bank_select_hi;
  logic [ADDR_W-1:0] addr, refreshRow, r0;
  logic [MASK_W-1:0] byteMask, dataOe;
  logic [DATA_W-1:0] dataIn, dataOut;
  logic [MODE_W-1:0] modeReg;
  logic selfRefresh, deepest_sleep, illegalCmd, seen;
  logic [4*DATA_W-1:0] wd, md;
  int failures = 0;
  int nTests = 0;

  // Core clock, 40 ns period
  always #20 core_clk = ~core_clk;

  sdrci_ctrl_model ctrl_u (.core_clk(core_clk), .clkEn(clkEn), .chipSel_n(chipSel_n),
    .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEn_n(writeEn_n),
    .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi), .addr(addr),
    .byteMask(byteMask), .dataIn(dataIn));
  sdrci_core dut_u (.core_clk(core_clk), .srst(srst), .clkEn(clkEn), .chipSel_n(chipSel_n),
    .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEn_n(writeEn_n),
    .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi), .addr(addr),
    .byteMask(byteMask), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .modeReg(modeReg),
    .selfRefresh(selfRefresh), .deepest_sleep(deepest_sleep), .illegalCmd(illegalCmd),
    .refreshRow(refreshRow));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Column word with the auto precharge flag folded in
  function automatic logic [ADDR_W-1:0] colAddr(input logic [COL_W-1:0] col, input logic ap);
    colAddr = ADDR_W'(col);
    colAddr[AUTO_PRECHARGE_BIT] = ap;
  endfunction
  // Idle cycles while watching for a refusal pulse; each of the n cycles is looked at
  task automatic nopWatch(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      #10;
      s = s | illegalCmd;
      ctrl_u.nop(1);
    end
  endtask
  // Write burst: command, then four beats of data and mask
  task automatic wrBurst(input logic [1:0] bank, input logic [COL_W-1:0] col, input logic ap,
                         input logic [4*DATA_W-1:0] d, input logic [4*MASK_W-1:0] m);
    ctrl_u.cyc(CMD_WRITE, bank, colAddr(col, ap), 1'b1, 2'h0, 16'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      ctrl_u.cyc(CMD_NOP, 2'h0, 13'h0, 1'b1, m[k*2 +: 2], d[k*16 +: 16], 1'b1);
    end
  endtask
  // Read burst: masks ride with the beats, enables and data are checked two cycles later
  task automatic rdBurst(input logic [1:0] bank, input logic [COL_W-1:0] col, input logic ap,
                         input logic [4*MASK_W-1:0] m, input logic [4*DATA_W-1:0] d);
    logic [MASK_W-1:0] oe;
    logic [DATA_W-1:0] be;
    ctrl_u.cyc(CMD_READ, bank, colAddr(col, ap), 1'b1, 2'h0, 16'h0, 1'b0);
    // Beat j drives the pins in the cycle that follows the edge one after its own
    for (int k = 1; k <= 5; k++) begin
      ctrl_u.cyc(CMD_NOP, 2'h0, 13'h0, 1'b1, (k <= 4) ? m[(k-1)*2 +: 2] : 2'h0, 16'h0, 1'b0);
      if (k >= 2) begin
        #10;
        oe = ~m[(k-2)*2 +: 2];
        be = {{8{oe[1]}}, {8{oe[0]}}};
        `CHK(dataOe, oe)
        `CHK(dataOut & be, d[(k-2)*16 +: 16] & be)
      end
    end
  endtask
  // Counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 400 cycles, so 2000 means a hang
  initial begin
    #(2000 * 40);
    failures++;
    conclude();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    @(posedge core_clk);
    #10;
    `CHK({modeReg, selfRefresh, deepest_sleep, illegalCmd, dataOe, refreshRow}, 30'h0)
    $display("test reset done");
    // A command pushed into the load delay is refused and leaves the banks idle
    ctrl_u.cyc(CMD_MODELOAD, 2'h0, 13'h1123, 1'b1, 2'h0, 16'h0, 1'b0);
    ctrl_u.cyc(CMD_ACTIVE, 2'h0, 13'h0001, 1'b1, 2'h0, 16'h0, 1'b0);
    nopWatch(2, seen);
    `CHK({seen, modeReg}, {1'b1, 12'h123})
    ctrl_u.modeLoad(13'h1a5c);
    #10;
    `CHK(modeReg, 12'ha5c)
    $display("test mode done");
    // Row open, full write, read back under a mixed mask, then a partial write merge
    ctrl_u.act(2'h1, 13'h0abc);
    wd = 64'h4444_3333_2222_1111;
    wrBurst(2'h1, 9'h004, 1'b0, wd, 8'h00);
    rdBurst(2'h1, 9'h004, 1'b0, 8'h18, wd);
    wrBurst(2'h1, 9'h004, 1'b0, 64'hdddd_cccc_bbbb_aaaa, 8'h39);
    md = 64'hdddd_3333_22bb_aa11;
    rdBurst(2'h1, 9'h004, 1'b0, 8'h00, md);
    $display("test data done");
    // Deselected read, deselected mode load and a no-operation start nothing
    for (int i = 0; i < 3; i++) begin
      ctrl_u.cyc((i == 0) ? 4'hd : (i == 1) ? 4'h8 : CMD_NOP, 2'h1, 13'h0fff, 1'b1, 2'h0, 16'h0, 1'b0);
      repeat (6) begin
        ctrl_u.nop(1);
        #10;
        `CHK({dataOe, illegalCmd, modeReg}, {3'h0, 12'ha5c})
      end
    end
    $display("test deselect done");
    // Auto precharge closes the row; a later read is refused until the bank is reopened
    rdBurst(2'h1, 9'h004, 1'b1, 8'h00, md);
    ctrl_u.nop(2);
    ctrl_u.cyc(CMD_READ, 2'h1, 13'h0004, 1'b1, 2'h0, 16'h0, 1'b0);
    nopWatch(6, seen);
    `CHK(seen, 1'b1)
    ctrl_u.cyc(CMD_ACTIVE, 2'h1, 13'h0002, 1'b1, 2'h0, 16'h0, 1'b0);
    nopWatch(2, seen);
    `CHK(seen, 1'b0)
    $display("test autoprecharge done");
    // Mode load with banks open is refused; single precharge spares bank 2, precharge-all does not
    ctrl_u.act(2'h2, 13'h0100);
    ctrl_u.cyc(CMD_MODELOAD, 2'h0, 13'h0fff, 1'b1, 2'h0, 16'h0, 1'b0);
    nopWatch(2, seen);
    `CHK({seen, modeReg}, {1'b1, 12'ha5c})
    ctrl_u.pre(2'h1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) ctrl_u.pre(2'h3, 1'b1);
      ctrl_u.cyc(CMD_READ, (i == 1) ? 2'h1 : 2'h2, 13'h0, 1'b1, 2'h0, 16'h0, 1'b0);
      nopWatch(6, seen);
      `CHK(seen, i != 0)
    end
    $display("test precharge done");
    // Terminate with clock enable high cuts the read: its last two beats never reach the pins
    ctrl_u.act(2'h0, 13'h0005);
    ctrl_u.cyc(CMD_READ, 2'h0, 13'h0, 1'b1, 2'h0, 16'h0, 1'b0);
    ctrl_u.nop(1);
    ctrl_u.cyc(CMD_TERM, 2'h0, 13'h0, 1'b1, 2'h0, 16'h0, 1'b0);
    for (int k = 3; k <= 6; k++) begin
      ctrl_u.nop(1);
      #10;
      if (k >= 4) `CHK({dataOe, deepest_sleep}, 3'h0)
    end
    ctrl_u.pre(2'h0, 1'b0);
    $display("test terminate done");
    // Auto refresh steps the row counter and ignores the address, bank and data pins
    r0 = refreshRow;
    ctrl_u.cyc(CMD_REFRESH, 2'h3, 13'h1fff, 1'b1, 2'h3, 16'hffff, 1'b1);
    ctrl_u.nop(REFRESH_CK + 1);
    #10;
    `CHK({refreshRow, selfRefresh, modeReg}, {r0 + 13'h0001, 1'b0, 12'ha5c})
    // Sleep entries hold while clock enable stays low and end once it returns high
    for (int i = 0; i < 2; i++) begin
      ctrl_u.cyc((i == 0) ? CMD_REFRESH : CMD_TERM, 2'h0, 13'h0, 1'b0, 2'h0, 16'h0, 1'b0);
      repeat (3) ctrl_u.cyc(CMD_NOP, 2'h0, 13'h0, 1'b0, 2'h0, 16'h0, 1'b0);
      #10;
      `CHK({selfRefresh, deepest_sleep}, (i == 0) ? 2'h2 : 2'h1)
      ctrl_u.nop(3);
      #10;
      `CHK({selfRefresh, deepest_sleep}, 2'h0)
    end
    $display("test refresh done");
    conclude();
  end
endmodule
